// *** lbmp_top.sv ***
// Behaviour
// - store-status is honoured only when stop-channel is issued in same cycle
// - read transfer end: stop plus store raise done and store on bus
// - error flags seen during transfer only feed error summary status bit 6
// - after stop no further data requests in later request cycles
// - input buffer nine bits loads at phase four, parity held
// - input byte goes to formatter nibbles or internal bus low byte
// - odd parity checked on input byte, error latched until cleared
// - link parity error sets status bit 0 and error summary bit 6
// - output buffer loads internal bus at phase four or formatter at two
// - odd parity computed and held on each output buffer load
// - output drivers disabled until transmit command
// - force even parity command inverts generated parity
// - predictor toggles on each parity one seen on any transfer
// - compatible command removes bits 32-35 parity from word parity
// - clear command resets predictor to zero
// - predictor state shows in status bit 1 and error summary bit 6
// - high density: odd toggles per nine byte transfer
// - industry compatible: even toggles per four byte transfer
// - core dump: even toggles per ten byte transfer
// - done on next data cycle after stop, store with it if issued
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`default_nettype none
module lbmp_top
    import lbmp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  link_in_data,
    input  wire logic        link_in_parity,
    input  wire logic        link_in_present,
    output logic [7:0]       link_out_data,
    output logic             link_out_parity,
    output logic             link_out_oe_n,
    input  wire logic [7:0]  formatter_byte,
    output logic [3:0]       formatter_nibble,
    output logic             formatter_nibble_valid,
    input  wire logic        upper_nibble_first_cmd,
    input  wire logic        formatter_shift_cmd,
    input  wire logic        channel_parity_error_cc,
    input  wire logic        channel_error_cc,
    input  wire logic        transfer_active,
    input  wire logic        request_cycle,
    input  wire logic        data_cycle,
    input  wire logic        chan_par_bit,
    input  wire logic        chan_par_valid,
    input  wire logic [35:0] chan_word,
    output logic             chan_request,
    output logic             chan_done,
    output logic             chan_store,
    output logic             mover_parity_check_cc,
    output logic             link_byte_parity_error_cc
);
    // ==========================================================
    // phase divider
    logic [1:0] phase_q;
    wire        ph2 = (phase_q == LBMP_PH_TWO);
    wire        ph4 = (phase_q == LBMP_PH_FOUR);
    always_ff @(posedge aclk) begin
        if (!aresetn) phase_q <= 2'd0;
        else          phase_q <= phase_q + 2'd1;
    end

    // ==========================================================
    // axi4-lite slave
    logic                aw_q, w_q, ar_q;
    logic [3:0]          awa_q, ara_q;
    logic [31:0]         wd_q;
    logic                bvalid_q, rvalid_q;
    logic [1:0]          bresp_q, rresp_q;
    logic [31:0]         rdata_q;
    logic [LBMP_CMD_W-1:0] cmd_pulse;
    logic [LBMP_CMD_W-1:0] cmd_hold_q;
    logic                dpe_q;
    wire do_wr = aw_q && w_q && !bvalid_q;
    // upper address bits map to an offset that no register decodes
    wire [3:0] aw_ofs = (|s_axi_awaddr[31:4]) ? 4'h1 : s_axi_awaddr[3:0];
    wire [3:0] ar_ofs = (|s_axi_araddr[31:4]) ? 4'h1 : s_axi_araddr[3:0];
    wire wr_ok = (awa_q == LBMP_CMD_OFS);
    wire rd_ok = (ara_q == LBMP_STATUS_OFS) || (ara_q == LBMP_INBUF_OFS)
              || (ara_q == LBMP_OUTBUF_OFS) || (ara_q == LBMP_CMD_OFS);
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready  = !w_q && !bvalid_q;
    assign s_axi_arready = !ar_q && !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign cmd_pulse = (do_wr && wr_ok && (&s_axi_wstrb[1:0] || 1'b1))
                     ? wd_q[LBMP_CMD_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awa_q    <= 4'h0;
            wd_q     <= 32'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= LBMP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q  <= 1'b1;
                awa_q <= aw_ofs;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q  <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? LBMP_RESP_OKAY : LBMP_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // commands held until the phase they act on
    logic [LBMP_CMD_W-1:0] cmd_act;
    wire [LBMP_CMD_W-1:0]  cmd_all = cmd_hold_q | cmd_pulse;
    always_comb begin
        cmd_act = '0;
        cmd_act[LBMP_CMD_RECV]    = cmd_all[LBMP_CMD_RECV] && ph4;
        cmd_act[LBMP_CMD_IB2OUT]  = cmd_all[LBMP_CMD_IB2OUT] && ph4;
        cmd_act[LBMP_CMD_FMT2OUT] = cmd_all[LBMP_CMD_FMT2OUT] && ph2;
        cmd_act[LBMP_CMD_STOP]    = cmd_all[LBMP_CMD_STOP] && ph4;
        cmd_act[LBMP_CMD_STORE]   = cmd_all[LBMP_CMD_STORE] && ph4;
        cmd_act[LBMP_CMD_XMIT]    = cmd_all[LBMP_CMD_XMIT];
        cmd_act[LBMP_CMD_CLRPRED] = cmd_all[LBMP_CMD_CLRPRED];
        cmd_act[LBMP_CMD_CLRLERR] = cmd_all[LBMP_CMD_CLRLERR];
        cmd_act[LBMP_CMD_COMPAT]  = cmd_all[LBMP_CMD_COMPAT];
        cmd_act[LBMP_CMD_FEVEN]   = cmd_all[LBMP_CMD_FEVEN];
        cmd_act[LBMP_CMD_SETDPE]  = cmd_all[LBMP_CMD_SETDPE];
        cmd_act[LBMP_CMD_CLRDPE]  = cmd_all[LBMP_CMD_CLRDPE];
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) cmd_hold_q <= '0;
        else          cmd_hold_q <= cmd_all & ~cmd_act;
    end

    // ==========================================================
    // link input buffer
    logic [7:0] inbuf_q;
    logic       inpar_q;
    logic       inbuf_full_q;
    logic       lerr_q;
    logic       in_chk_q;
    wire        in_load = cmd_act[LBMP_CMD_RECV] && link_in_present;
    // odd parity check, once per loaded byte
    wire        in_bad  = in_chk_q && !(^{inbuf_q, inpar_q});
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inbuf_q      <= 8'h00;
            inpar_q      <= 1'b0;
            inbuf_full_q <= 1'b0;
        end else if (in_load) begin
            inbuf_q      <= link_in_data;
            inpar_q      <= link_in_parity;
            inbuf_full_q <= 1'b1;
        end
    end
    // check pulse so a clear is not undone by a stale byte
    always_ff @(posedge aclk) begin
        if (!aresetn) in_chk_q <= 1'b0;
        else          in_chk_q <= in_load;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)                       lerr_q <= 1'b0;
        else if (in_bad && !in_load)        lerr_q <= 1'b1;
        else if (cmd_act[LBMP_CMD_CLRLERR]) lerr_q <= 1'b0;
    end
    assign link_byte_parity_error_cc = lerr_q;
    logic [3:0] nib_q;
    logic       nibv_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nib_q  <= 4'h0;
            nibv_q <= 1'b0;
        end else begin
            nibv_q <= formatter_shift_cmd && inbuf_full_q;
            nib_q  <= upper_nibble_first_cmd ? inbuf_q[7:4] : inbuf_q[3:0];
        end
    end
    assign formatter_nibble       = nib_q;
    assign formatter_nibble_valid = nibv_q;

    // ==========================================================
    // link output buffer
    logic [7:0] outbuf_q;
    logic       outpar_q, xmit_q, feven_q;
    wire        out_ib  = cmd_act[LBMP_CMD_IB2OUT];
    wire        out_ld  = out_ib || cmd_act[LBMP_CMD_FMT2OUT];
    wire [7:0]  out_mux = out_ib ? wd_q[23:16] : formatter_byte;
    wire        out_par = ~(^out_mux) ^ feven_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            outbuf_q <= 8'h00;
            outpar_q <= 1'b1;
            xmit_q   <= 1'b0;
            feven_q  <= 1'b0;
        end else begin
            if (cmd_pulse[LBMP_CMD_FEVEN] || cmd_pulse[LBMP_CMD_CLRDPE])
                feven_q <= cmd_pulse[LBMP_CMD_FEVEN];
            if (out_ld) begin
                outbuf_q <= out_mux;
                outpar_q <= out_par;
                xmit_q   <= 1'b0;
            end else if (cmd_act[LBMP_CMD_XMIT]) begin
                xmit_q <= 1'b1;
            end
        end
    end
    assign link_out_oe_n   = !xmit_q;
    assign link_out_data   = outbuf_q;
    assign link_out_parity = outpar_q;

    // ==========================================================
    // parity predictor
    logic pred_q;
    wire  chan_ones = chan_par_bit ^ (cmd_act[LBMP_CMD_COMPAT] && (^chan_word[35:32]));
    wire  tog = (chan_par_valid && chan_ones) ^ (in_load && link_in_parity)
              ^ (cmd_act[LBMP_CMD_XMIT] && outpar_q);
    always_ff @(posedge aclk) begin
        if (!aresetn)                       pred_q <= 1'b0;
        else if (cmd_act[LBMP_CMD_CLRPRED]) pred_q <= 1'b0;
        else if (tog)                       pred_q <= ~pred_q;
    end
    assign mover_parity_check_cc = pred_q;

    // datapath error bit set by microcode
    always_ff @(posedge aclk) begin
        if (!aresetn)                      dpe_q <= 1'b0;
        else if (cmd_act[LBMP_CMD_SETDPE]) dpe_q <= 1'b1;
        else if (cmd_act[LBMP_CMD_CLRDPE]) dpe_q <= 1'b0;
    end

    // ==========================================================
    // channel stop and store
    logic stop_pend_q, store_pend_q, stopped_q, done_q, store_q;
    wire  stop_cmd  = cmd_act[LBMP_CMD_STOP];
    wire  store_cmd = cmd_act[LBMP_CMD_STORE] && stop_cmd;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_pend_q  <= 1'b0;
            store_pend_q <= 1'b0;
            stopped_q    <= 1'b0;
            done_q       <= 1'b0;
            store_q      <= 1'b0;
        end else begin
            done_q  <= 1'b0;
            store_q <= 1'b0;
            if (stop_cmd) begin
                stop_pend_q  <= 1'b1;
                store_pend_q <= store_cmd;
                stopped_q    <= 1'b1;
            end else if (stop_pend_q && data_cycle) begin
                // done with store next data cycle
                done_q       <= 1'b1;
                store_q      <= store_pend_q;
                stop_pend_q  <= 1'b0;
                store_pend_q <= 1'b0;
            end
            if (!transfer_active && !stop_pend_q && !stop_cmd) stopped_q <= 1'b0;
        end
    end
    assign chan_done  = done_q;
    assign chan_store = store_q;
    assign chan_request = request_cycle && transfer_active && !stopped_q && !stop_cmd;

    // ==========================================================
    // read path
    // error summary for microcode
    wire err_any = channel_parity_error_cc || pred_q || channel_error_cc || lerr_q;
    wire [31:0] status_w = {5'h0, dpe_q, 19'h0, err_any, inpar_q, feven_q,
                            xmit_q, stopped_q, pred_q, lerr_q};
    wire [31:0] rd_mux = (ara_q == LBMP_STATUS_OFS) ? status_w
                       : (ara_q == LBMP_INBUF_OFS)  ? {23'h0, inpar_q, inbuf_q}
                       : (ara_q == LBMP_OUTBUF_OFS) ? {23'h0, outpar_q, outbuf_q}
                       : 32'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_q     <= 1'b0;
            ara_q    <= 4'h0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= LBMP_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_q  <= 1'b1;
                ara_q <= ar_ofs;
            end
            if (ar_q && !rvalid_q) begin
                ar_q     <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_ok ? rd_mux : 32'h0;
                rresp_q <= rd_ok ? LBMP_RESP_OKAY : LBMP_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    store_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        chan_store |-> chan_done) else $error("store without done");
    no_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stopped_q |-> !chan_request) else $error("request after stop");
    done_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_pend_q && !stop_cmd && data_cycle) |=> chan_done)
        else $error("done missing");
    lerr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_bad && !in_load) |=> link_byte_parity_error_cc) else $error("parity err lost");
    in_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_load |-> ph4) else $error("input load off phase");
    oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
        out_ld |=> link_out_oe_n) else $error("driven before transmit");
    out_par_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (out_ld && !feven_q) |=> ^{link_out_data, link_out_parity})
        else $error("output parity not odd");
    out_even_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (out_ld && feven_q) |=> !(^{link_out_data, link_out_parity}))
        else $error("output parity not even");
    pred_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_act[LBMP_CMD_CLRPRED] |=> !mover_parity_check_cc) else $error("predictor not clear");
    pred_tog_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tog && !cmd_act[LBMP_CMD_CLRPRED]) |=> (pred_q != $past(pred_q)))
        else $error("predictor not toggled");
    stop_store_c: cover property (@(posedge aclk) chan_done && chan_store);
    xmit_c:       cover property (@(posedge aclk) !link_out_oe_n);
    lerr_c:       cover property (@(posedge aclk) link_byte_parity_error_cc);
    compat_c:     cover property (@(posedge aclk) cmd_act[LBMP_CMD_COMPAT] && chan_par_valid);
endmodule // lbmp_top
`default_nettype wire

// *** lbmp_pkg.sv ***
`default_nettype none
package lbmp_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] LBMP_CMD_OFS    = 4'h0;
    localparam logic [3:0] LBMP_STATUS_OFS = 4'h4;
    localparam logic [3:0] LBMP_INBUF_OFS  = 4'h8;
    localparam logic [3:0] LBMP_OUTBUF_OFS = 4'hc;
    // ==========================================================
    // command register bit positions (write pulses)
    localparam int LBMP_CMD_RECV     = 0;
    localparam int LBMP_CMD_IB2OUT   = 1;
    localparam int LBMP_CMD_FMT2OUT  = 2;
    localparam int LBMP_CMD_XMIT     = 3;
    localparam int LBMP_CMD_STOP     = 4;
    localparam int LBMP_CMD_STORE    = 5;
    localparam int LBMP_CMD_CLRPRED  = 6;
    localparam int LBMP_CMD_CLRLERR  = 7;
    localparam int LBMP_CMD_COMPAT   = 8;
    localparam int LBMP_CMD_FEVEN    = 9;
    localparam int LBMP_CMD_SETDPE   = 10;
    localparam int LBMP_CMD_CLRDPE   = 11;
    localparam int LBMP_CMD_W        = 12;
    // ==========================================================
    // status bit positions
    localparam int LBMP_ST_LERR   = 0;
    localparam int LBMP_ST_PRED   = 1;
    localparam int LBMP_ST_STOP   = 2;
    localparam int LBMP_ST_XMIT   = 3;
    localparam int LBMP_ST_FEVEN  = 4;
    localparam int LBMP_ST_INPAR  = 5;
    localparam int LBMP_ST_DPE    = 26;
    // ==========================================================
    // axi responses and phase count
    localparam logic [1:0] LBMP_RESP_OKAY   = 2'b00;
    localparam logic [1:0] LBMP_RESP_SLVERR = 2'b10;
    localparam int         LBMP_PHASES      = 4;
    localparam logic [1:0] LBMP_PH_TWO      = 2'd1;
    localparam logic [1:0] LBMP_PH_FOUR     = 2'd3;
endpackage : lbmp_pkg
`default_nettype wire

// *** lbmp_far_model.sv ***
`default_nettype none
module lbmp_far_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] send_byte,
    input  wire logic       send_bad,
    input  wire logic       send_en,
    input  wire logic       chan_done,
    input  wire logic       chan_store,
    output logic [7:0]      link_in_data,
    output logic            link_in_parity,
    output logic            link_in_present,
    output logic            request_cycle,
    output logic            data_cycle,
    output logic            status_stored
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] slot_q;
    // ==========================================================
    // slot timing and link byte source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_q          <= 2'h0;
            status_stored   <= 1'b0;
            link_in_present <= 1'b0;
            link_in_data    <= 8'h00;
            link_in_parity  <= 1'b0;
        end else begin
            slot_q          <= slot_q + 2'h1;
            link_in_present <= send_en;
            if (send_en) begin
                link_in_data   <= send_byte;
                link_in_parity <= ~(^send_byte) ^ send_bad;
            end else begin
                link_in_data   <= ~link_in_data;
                link_in_parity <= ~link_in_parity;
            end
            if (chan_done && chan_store) begin
                status_stored <= 1'b1;
            end
        end
    end
    assign request_cycle = (slot_q == 2'h1);
    assign data_cycle    = (slot_q == 2'h3);
endmodule // lbmp_far_model
`default_nettype wire

// *** lbmp_tb_top.sv ***
`default_nettype none
module lbmp_tb_top;
    import lbmp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_CMD = 32'(LBMP_CMD_OFS);
    localparam logic [31:0] A_ST  = 32'(LBMP_STATUS_OFS);
    localparam logic [31:0] A_IN  = 32'(LBMP_INBUF_OFS);
    localparam logic [31:0] A_OUT = 32'(LBMP_OUTBUF_OFS);
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, rd;
    logic [3:0]  s_axi_wstrb, formatter_nibble;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, link_in_parity, link_in_present, link_out_parity;
    logic [7:0]  link_in_data, link_out_data, formatter_byte, send_byte, b, e;
    logic        link_out_oe_n, formatter_nibble_valid, upper_nibble_first_cmd;
    logic        formatter_shift_cmd, channel_parity_error_cc, channel_error_cc;
    logic        transfer_active, request_cycle, data_cycle, chan_par_bit, chan_par_valid;
    logic [35:0] chan_word;
    logic        chan_request, chan_done, chan_store, mover_parity_check_cc, p;
    logic        link_byte_parity_error_cc, send_bad, send_en, status_stored;
    int          num_errors, tests_run, done_cnt, store_cnt, req_cnt;
    lbmp_top lbmp_top_inst (.*);
    lbmp_far_model lbmp_far_model_inst (.*);
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        done_cnt  <= done_cnt + int'(chan_done);
        store_cnt <= store_cnt + int'(chan_store);
        req_cnt   <= req_cnt + int'(chan_request);
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic odd_par(input logic [7:0] v);
        return ~(^v);
    endfunction
    function automatic logic [31:0] cb(input int i);
        return 32'h1 << i;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        final_report();
    endtask
    // ==========================================================
    // axi4-lite master, ready sampled before each rising edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_h, w_h, b_h;
        int   n;
        n = 0;
        b_h = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_h) begin
            @(negedge aclk);
            aw_h = s_axi_awvalid & s_axi_awready;
            w_h = s_axi_wvalid & s_axi_wready;
            b_h = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_h) s_axi_awvalid <= 1'b0;
            if (w_h) s_axi_wvalid <= 1'b0;
            if (b_h) s_axi_bready <= 1'b0;
            n++;
            if (n > 100) hang();
        end
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_h, r_h;
        int   n;
        n = 0;
        r_h = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_h) begin
            @(negedge aclk);
            ar_h = s_axi_arvalid & s_axi_arready;
            r_h = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_h) s_axi_arvalid <= 1'b0;
            if (r_h) s_axi_rready <= 1'b0;
            n++;
            if (n > 100) hang();
        end
    endtask
    task automatic cmd(input logic [31:0] bits);
        axi_wr(A_CMD, bits, rs);
        chk("cmd bresp", 32'(LBMP_RESP_OKAY), 32'(rs));
        repeat (LBMP_PHASES) @(posedge aclk);
    endtask
    task automatic st_bit(input string what, input int i, input logic exp);
        axi_rd(A_ST, rd, rs);
        chk(what, 32'(exp), 32'(rd[i]));
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, send_en, send_bad, channel_parity_error_cc, channel_error_cc} = '0;
        {transfer_active, chan_par_bit, chan_par_valid} = '0;
        {upper_nibble_first_cmd, formatter_shift_cmd} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {formatter_byte, send_byte} = '0;
        chan_word = '0;
        {num_errors, tests_run, done_cnt, store_cnt, req_cnt} = '0;
        seed = 32'hb0200f2a;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("oe_n reset", 32'h1, 32'(link_out_oe_n));
        chk("out parity reset", 32'h1, 32'(link_out_parity));
        chk("done reset", 32'h0, 32'({chan_done, chan_store, mover_parity_check_cc}));
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            seed = xs(seed);
            b = seed[7:0];
            send_byte <= b;
            send_bad <= i[0];
            send_en <= 1'b1;
            upper_nibble_first_cmd <= seed[8];
            formatter_shift_cmd <= seed[9];
            cmd(cb(LBMP_CMD_CLRPRED) | cb(LBMP_CMD_CLRLERR));
            cmd(cb(LBMP_CMD_RECV));
            send_en <= 1'b0;
            axi_rd(A_IN, rd, rs);
            chk("inbuf", {23'h0, odd_par(b) ^ i[0], b}, rd);
            @(negedge aclk);
            chk("link err", 32'(i[0]), 32'(link_byte_parity_error_cc));
            chk("predictor", 32'(odd_par(b) ^ i[0]), 32'(mover_parity_check_cc));
            e = {3'h0, seed[9], (seed[8] ? b[7:4] : b[3:0])};
            chk("nibble", 32'(e), {27'h0, formatter_nibble_valid, formatter_nibble});
        end
        cmd(cb(LBMP_CMD_CLRLERR));
        st_bit("link err cleared", LBMP_ST_LERR, 1'b0);
        $display("test input buffer done");
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            seed = xs(seed);
            b = seed[15:8];
            formatter_byte <= seed[7:0];
            e = i[0] ? seed[7:0] : b;
            p = odd_par(e) ^ i[1];
            if (i[1]) cmd(cb(LBMP_CMD_FEVEN));
            if (i[0]) cmd(cb(LBMP_CMD_FMT2OUT));
            else cmd(cb(LBMP_CMD_IB2OUT) | {8'h0, b, 16'h0});
            axi_rd(A_OUT, rd, rs);
            chk("outbuf", {23'h0, p, e}, rd);
            chk("oe before xmit", 32'h1, 32'(link_out_oe_n));
            cmd(cb(LBMP_CMD_XMIT));
            @(negedge aclk);
            chk("oe on xmit", 32'h0, 32'(link_out_oe_n));
            chk("link out", {23'h0, p, e}, {23'h0, link_out_parity, link_out_data});
            if (i[1]) cmd(cb(LBMP_CMD_CLRDPE));
        end
        $display("test output buffer done");
        cmd(cb(LBMP_CMD_SETDPE));
        st_bit("dpe set", LBMP_ST_DPE, 1'b1);
        cmd(cb(LBMP_CMD_CLRDPE) | cb(LBMP_CMD_CLRPRED));
        st_bit("dpe clear", LBMP_ST_DPE, 1'b0);
        channel_error_cc <= 1'b1;
        st_bit("any error", 6, 1'b1);
        channel_error_cc <= 1'b0;
        chan_word <= {seed[3:0], seed};
        chan_par_bit <= 1'b1;
        chan_par_valid <= 1'b1;
        @(posedge aclk);
        chan_par_valid <= 1'b0;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("chan toggle", 32'h1, 32'(mover_parity_check_cc));
        cmd(cb(LBMP_CMD_CLRPRED));
        chan_par_bit <= 1'b0;
        chan_word <= 36'h100000000;
        chan_par_valid <= 1'b1;
        cmd(cb(LBMP_CMD_COMPAT));
        chan_par_valid <= 1'b0;
        @(negedge aclk);
        chk("compat predict", 32'h1, 32'(mover_parity_check_cc));
        $display("test error flags done");
        @(posedge aclk);
        transfer_active <= 1'b1;
        cmd(cb(LBMP_CMD_STORE));
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("store alone", 32'h0, 32'(done_cnt + store_cnt));
        cmd(cb(LBMP_CMD_STOP) | cb(LBMP_CMD_STORE));
        @(negedge aclk);
        req_cnt = 0;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("done count", 32'h1, 32'(done_cnt));
        chk("store count", 32'h1, 32'(store_cnt));
        chk("requests after stop", 32'h0, 32'(req_cnt));
        chk("status logged", 32'h1, 32'(status_stored));
        st_bit("stopped", LBMP_ST_STOP, 1'b1);
        transfer_active <= 1'b0;
        $display("test channel stop done");
        axi_wr(A_ST, 32'h1, rs);
        chk("bad write resp", 32'(LBMP_RESP_SLVERR), 32'(rs));
        axi_rd(32'h10, rd, rs);
        chk("bad read resp", {30'h0, LBMP_RESP_SLVERR}, {30'h0, rs});
        chk("bad read data", 32'h0, rd);
        $display("test register map done");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        hang();
    end
endmodule // lbmp_tb_top
`default_nettype wire
